// ### include/txd_pkg.sv
// Shared constants and types of the transmit descriptor engine
package txd_pkg;

   // Register byte addresses on the plain register port
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_PTR = 8'h08;
   localparam logic [7:0] REG_ISR = 8'h0C;
   localparam logic [7:0] REG_IMR = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;

   // Command register fields
   localparam int CMD_GO_BIT = 0;

   // Transmit configuration fields and reset value
   localparam int CFG_THR_LSB = 0;
   localparam int CFG_THR_W = 12;
   localparam int CFG_DLEN_LSB = 16;
   localparam int CFG_DLEN_W = 4;
   localparam logic [31:0] CFG_RESET = 32'h0003_0040;

   // Pointer reset value
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;

   // Descriptor word indices within a descriptor read
   localparam logic [1:0] DW_LINK = 2'h0;
   localparam logic [1:0] DW_CMDSTS = 2'h1;
   localparam logic [1:0] DW_BUFPTR = 2'h2;

   // Command/status word fields
   localparam int CS_OWN_BIT = 31;
   localparam int CS_MORE_BIT = 30;
   localparam int CS_SIZE_W = 12;

   // Byte figures of the bus requests
   localparam logic [15:0] LINK_BYTES = 16'h0004;
   localparam logic [15:0] STATUS_BYTES = 16'h0002;
   localparam logic [31:0] STATUS_OFS = 32'h0000_0006;

   // Interrupt status bit positions
   localparam int EV_IDLE = 0;
   localparam int EV_PKT = 1;
   localparam int EV_DWR = 2;
   localparam int EV_W = 3;

   // Bus master request kinds
   typedef enum logic [1:0] {
      TXD_K_DREAD = 2'h0,
      TXD_K_DREFR = 2'h1,
      TXD_K_FRAG = 2'h2,
      TXD_K_SWR = 2'h3
   } txd_kind_t;

   // Engine states, Gray coded along the main path
   typedef enum logic [2:0] {
      TXD_IDLE = 3'h0,
      TXD_DREAD = 3'h1,
      TXD_FBLOCK = 3'h3,
      TXD_FREAD = 3'h2,
      TXD_DWRITE = 3'h6,
      TXD_ADV = 3'h7,
      TXD_DREFR = 3'h5
   } txd_state_t;

endpackage

// ### logic/txd_irq.sv
// Sticky interrupt status, mask and level interrupt output
module txd_irq
   import txd_pkg::*;
#(
   parameter int W = EV_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] ev,
   input wire logic status_rd,
   input wire logic mask_wr,
   input wire logic [W-1:0] mask_wdata,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);

   // Sticky bits: a read clears, but an event in that cycle survives
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
      end else if (ce) begin
         status <= (status_rd ? '0 : status) | ev;
      end
   end

   // Mask register, all sources masked after reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= '0;
      end else if (ce && mask_wr) begin
         mask <= mask_wdata;
      end
   end

   // Registered level output, one cycle behind the status bits
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status & mask);
      end
   end
endmodule

// ### logic/txd_desc_cache.sv
// One-entry transmit descriptor cache: link, command/status, fragment
module txd_desc_cache
   import txd_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [1:0] wr_index,
   input wire logic [31:0] wr_data,
   input wire logic adv_en,
   input wire logic [CS_SIZE_W-1:0] adv_bytes,
   output logic [31:0] link,
   output logic [31:0] cmdsts,
   output logic [31:0] fragment_pointer,
   output logic [CS_SIZE_W-1:0] descriptor_byte_count
);

   // Words land by index; a refresh only brings the link word
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         link <= '0;
         cmdsts <= '0;
      end else if (ce && wr_en) begin
         if (wr_index == DW_LINK) begin
            link <= wr_data;
         end
         if (wr_index == DW_CMDSTS) begin
            cmdsts <= wr_data;
         end
      end
   end

   // Fragment pair, advanced by each granted data burst
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fragment_pointer <= '0;
         descriptor_byte_count <= '0;
      end else if (ce) begin
         if (wr_en && wr_index == DW_BUFPTR) begin
            fragment_pointer <= wr_data;
         end else if (adv_en) begin
            fragment_pointer <= fragment_pointer + 32'(adv_bytes);
         end
         if (wr_en && wr_index == DW_CMDSTS) begin
            descriptor_byte_count <= wr_data[CS_SIZE_W-1:0];
         end else if (adv_en) begin
            descriptor_byte_count <= descriptor_byte_count - adv_bytes;
         end
      end
   end

endmodule

// ### logic/txd_dma.sv
// Transmit descriptor engine: list walker, cache, FIFO fill and handles
//
// Overview of operation
// - Idle, go set, done clear: read descriptor at pointer, config length.
// - Idle, go set, done set: read only the link word, then advance.
// - After descriptor read: owned waits for space, else idle plus status.
// - Space above threshold: burst min(free, remaining), reduce remaining.
// - Zero left, more-fragments set: write status clearing owner, advance.
// - Zero left, more-fragments clear: push pointer into FIFO as handle.
// - Data burst done returns to space wait; status write done advances.
// - Advance, non-null link: load pointer, clear done, read descriptor.
// - Advance, null link: set done, idle status, clear go, go idle.
// - Done flag clears on every pointer load, by engine or software.
// - Descriptor address sits in a 32-bit software-writable register.
// - Cache holds one fragment pointer and byte count pair.
// - Free space is FIFO size minus fill; usable only above threshold.
//
// Added by the designer: the placing of the registers and the strobed register port.
module txd_dma
   import txd_pkg::*;
#(
   parameter int FIFO_BYTES = 2048,
   parameter int FILL_W = 12
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic mreq,
   output txd_kind_t mreq_kind,
   output logic [31:0] mreq_addr,
   output logic [15:0] mreq_len,
   output logic [15:0] mreq_wdata,
   input wire logic bus_transfer_complete,
   input wire logic mrd_valid,
   input wire logic [1:0] mrd_index,
   input wire logic [31:0] mrd_data,
   input wire logic [FILL_W-1:0] tx_fifo_fill_bytes,
   output logic handle_push,
   output logic [31:0] handle_data
);

   localparam logic [FILL_W-1:0] FIFO_SIZE = FILL_W'(FIFO_BYTES);

   // Reset release copy
   logic rst_meta_q;
   logic rst_n;

   // Software visible state
   logic transmit_go_bit;
   logic [31:0] tx_config_register;
   logic [31:0] tx_descriptor_pointer;
   logic current_desc_done_flag;

   // Engine state
   txd_state_t state_q;
   txd_state_t state_d;

   // Cache outputs
   logic [31:0] c_link;
   logic [31:0] c_cmdsts;
   logic [31:0] fragment_pointer;
   logic [CS_SIZE_W-1:0] descriptor_byte_count;

   // FIFO space and burst sizing
   logic [FILL_W-1:0] tx_fifo_free_bytes;
   logic [FILL_W-1:0] tx_fill_threshold_a;
   logic fifo_space_ok;
   logic [CS_SIZE_W-1:0] burst_bytes;

   // Register decode strobes
   logic wr_cmd;
   logic wr_cfg;
   logic wr_ptr;
   logic wr_imr;
   logic rd_isr;

   // Engine actions decided combinationally
   logic go_clear;
   logic done_set;
   logic ptr_load;
   logic frag_adv;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] int_status;
   logic [EV_W-1:0] int_mask;

   // Release reset through two flops so the engine leaves reset cleanly
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else if (ce) begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Decode of the plain register port
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   assign wr_cmd = reg_wr && hit(reg_addr, REG_CMD);
   assign wr_cfg = reg_wr && hit(reg_addr, REG_CFG);
   assign wr_ptr = reg_wr && hit(reg_addr, REG_PTR);
   assign wr_imr = reg_wr && hit(reg_addr, REG_IMR);
   assign rd_isr = reg_rd && hit(reg_addr, REG_ISR);

   // Configuration register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_config_register <= CFG_RESET;
      end else if (ce && wr_cfg) begin
         tx_config_register <= reg_wdata;
      end
   end

   assign tx_fill_threshold_a =
      tx_config_register[CFG_THR_LSB +: CFG_THR_W];

   // Go bit: software writes one to set; the engine clears at list end.
   // A software set in the same cycle wins so a fresh append is not lost.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         transmit_go_bit <= 1'b0;
      end else if (ce) begin
         if (wr_cmd && reg_wdata[CMD_GO_BIT]) begin
            transmit_go_bit <= 1'b1;
         end else if (go_clear) begin
            transmit_go_bit <= 1'b0;
         end
      end
   end

   // Descriptor pointer, software write takes precedence over engine load
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_descriptor_pointer <= PTR_RESET;
      end else if (ce) begin
         if (wr_ptr) begin
            tx_descriptor_pointer <= reg_wdata;
         end else if (ptr_load) begin
            tx_descriptor_pointer <= c_link;
         end
      end
   end

   // Done flag: any pointer load clears it, list end sets it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         current_desc_done_flag <= 1'b0;
      end else if (ce) begin
         if (wr_ptr || ptr_load) begin
            current_desc_done_flag <= 1'b0;
         end else if (done_set) begin
            current_desc_done_flag <= 1'b1;
         end
      end
   end

   // Free space against the fill threshold
   assign tx_fifo_free_bytes = FIFO_SIZE - tx_fifo_fill_bytes;
   assign fifo_space_ok = tx_fifo_free_bytes > tx_fill_threshold_a;

   // Burst is the smaller of free space and what the descriptor still holds
   assign burst_bytes =
      (CS_SIZE_W'(tx_fifo_free_bytes) < descriptor_byte_count) ?
      CS_SIZE_W'(tx_fifo_free_bytes) : descriptor_byte_count;

   // Cached descriptor; only accept bus words while a read is outstanding
   txd_desc_cache u_cache (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .wr_en(mrd_valid &&
             (state_q == TXD_DREAD || state_q == TXD_DREFR)),
      .wr_index(mrd_index),
      .wr_data(mrd_data),
      .adv_en(frag_adv),
      .adv_bytes(burst_bytes),
      .link(c_link),
      .cmdsts(c_cmdsts),
      .fragment_pointer(fragment_pointer),
      .descriptor_byte_count(descriptor_byte_count)
   );

   // Next state and the side actions taken on each transition
   always_comb begin
      state_d = state_q;
      go_clear = 1'b0;
      done_set = 1'b0;
      ptr_load = 1'b0;
      frag_adv = 1'b0;
      events = '0;
      case (state_q)
         TXD_IDLE: begin
            if (transmit_go_bit && !current_desc_done_flag) begin
               state_d = TXD_DREAD;
            end else if (transmit_go_bit) begin
               state_d = TXD_DREFR;
            end
         end
         TXD_DREFR: begin
            if (bus_transfer_complete) begin
               state_d = TXD_ADV;
            end
         end
         TXD_DREAD: begin
            if (bus_transfer_complete && c_cmdsts[CS_OWN_BIT]) begin
               state_d = TXD_FBLOCK;
            end else if (bus_transfer_complete) begin
               state_d = TXD_IDLE;
               events[EV_IDLE] = 1'b1;
            end
         end
         TXD_FBLOCK: begin
            // An exhausted descriptor is closed before any space check
            if (descriptor_byte_count == '0 && c_cmdsts[CS_MORE_BIT]) begin
               state_d = TXD_DWRITE;
            end else if (descriptor_byte_count == '0) begin
               state_d = TXD_ADV;
               events[EV_PKT] = 1'b1;
            end else if (fifo_space_ok) begin
               state_d = TXD_FREAD;
               frag_adv = 1'b1;
            end
         end
         TXD_FREAD: begin
            if (bus_transfer_complete) begin
               state_d = TXD_FBLOCK;
            end
         end
         TXD_DWRITE: begin
            if (bus_transfer_complete) begin
               state_d = TXD_ADV;
               events[EV_DWR] = 1'b1;
            end
         end
         TXD_ADV: begin
            if (c_link != '0) begin
               state_d = TXD_DREAD;
               ptr_load = 1'b1;
            end else begin
               state_d = TXD_IDLE;
               done_set = 1'b1;
               go_clear = 1'b1;
               events[EV_IDLE] = 1'b1;
            end
         end
         default: begin
            state_d = TXD_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TXD_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // Bus master requests: a one-cycle pulse with kind, address and length.
   // The pointer used is the one that will be current after this edge.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mreq <= 1'b0;
         mreq_kind <= TXD_K_DREAD;
         mreq_addr <= '0;
         mreq_len <= '0;
         mreq_wdata <= '0;
      end else if (ce) begin
         mreq <= 1'b0;
         if (state_q == TXD_IDLE && state_d == TXD_DREAD) begin
            mreq <= 1'b1;
            mreq_kind <= TXD_K_DREAD;
            mreq_addr <= tx_descriptor_pointer;
            mreq_len <= {10'h000,
               tx_config_register[CFG_DLEN_LSB +: CFG_DLEN_W], 2'h0};
         end else if (state_d == TXD_DREFR && state_q == TXD_IDLE) begin
            mreq <= 1'b1;
            mreq_kind <= TXD_K_DREFR;
            mreq_addr <= tx_descriptor_pointer;
            mreq_len <= LINK_BYTES;
         end else if (state_d == TXD_FREAD && state_q == TXD_FBLOCK) begin
            mreq <= 1'b1;
            mreq_kind <= TXD_K_FRAG;
            mreq_addr <= fragment_pointer;
            mreq_len <= 16'(burst_bytes);
         end else if (state_d == TXD_DWRITE && state_q == TXD_FBLOCK) begin
            // Only the upper half of command/status goes back, owner cleared
            mreq <= 1'b1;
            mreq_kind <= TXD_K_SWR;
            mreq_addr <= tx_descriptor_pointer + STATUS_OFS;
            mreq_len <= STATUS_BYTES;
            mreq_wdata <= {1'b0, c_cmdsts[30:16]};
         end else if (ptr_load) begin
            mreq <= 1'b1;
            mreq_kind <= TXD_K_DREAD;
            mreq_addr <= c_link;
            mreq_len <= {10'h000,
               tx_config_register[CFG_DLEN_LSB +: CFG_DLEN_W], 2'h0};
         end
      end
   end

   // Packet handle: the descriptor address follows the last data byte into
   // the FIFO so the completion path can find the last descriptor.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         handle_push <= 1'b0;
         handle_data <= '0;
      end else if (ce) begin
         handle_push <= events[EV_PKT];
         if (events[EV_PKT]) begin
            handle_data <= tx_descriptor_pointer;
         end
      end
   end

   // Interrupt status, mask and output
   txd_irq #(
      .W(EV_W)
   ) u_irq (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .ev(events),
      .status_rd(rd_isr),
      .mask_wr(wr_imr),
      .mask_wdata(reg_wdata[EV_W-1:0]),
      .status(int_status),
      .mask(int_mask),
      .irq(irq)
   );

   // Read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               REG_CMD: reg_rdata <= {31'h0, transmit_go_bit};
               REG_CFG: reg_rdata <= tx_config_register;
               REG_PTR: reg_rdata <= tx_descriptor_pointer;
               REG_ISR: reg_rdata <= {29'h0, int_status};
               REG_IMR: reg_rdata <= {29'h0, int_mask};
               REG_STAT: reg_rdata <= {13'h0, state_q,
                  3'h0, current_desc_done_flag, descriptor_byte_count};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

endmodule

// ### tb/txd_dma_sva.sv
// Port checks of the transmit descriptor engine
module txd_dma_sva
   import txd_pkg::*;
#(
   parameter int FIFO_BYTES = 2048,
   parameter int FILL_W = 12
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic mreq,
   input txd_kind_t mreq_kind,
   input wire logic [31:0] mreq_addr,
   input wire logic [15:0] mreq_len,
   input wire logic [15:0] mreq_wdata,
   input wire logic [FILL_W-1:0] tx_fifo_fill_bytes,
   input wire logic handle_push,
   input wire logic [31:0] handle_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] cfg_q, desc_q;
   // Software copy of the configuration; the engine never writes it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_q <= CFG_RESET;
      end else if (ce && reg_wr && reg_addr == REG_CFG) begin
         cfg_q <= reg_wdata;
      end
   end
   // Last full descriptor read names the packet a handle must carry
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         desc_q <= 32'h0000_0000;
      end else if (mreq && mreq_kind == TXD_K_DREAD) begin
         desc_q <= mreq_addr;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   desc_len_a: assert property (mreq && mreq_kind == TXD_K_DREAD |->
      mreq_len == {10'h000, cfg_q[CFG_DLEN_LSB +: CFG_DLEN_W], 2'h0})
      else $error("descriptor read length wrong");
   refr_len_a: assert property (mreq && mreq_kind == TXD_K_DREFR |->
      mreq_len == LINK_BYTES) else $error("link refresh length wrong");
   status_req_a: assert property (mreq && mreq_kind == TXD_K_SWR |->
      mreq_len == STATUS_BYTES && !mreq_wdata[15])
      else $error("status write keeps ownership");
   status_addr_a: assert property (mreq && mreq_kind == TXD_K_SWR |->
      mreq_addr == desc_q + STATUS_OFS) else $error("status address wrong");
   frag_fit_a: assert property (mreq && mreq_kind == TXD_K_FRAG |->
      mreq_len != 16'h0000 && int'(mreq_len) <=
      FIFO_BYTES - int'($past(tx_fifo_fill_bytes)))
      else $error("fragment burst exceeds free space");
   frag_thr_a: assert property (mreq && mreq_kind == TXD_K_FRAG |->
      FIFO_BYTES - int'($past(tx_fifo_fill_bytes)) >
      int'(cfg_q[CFG_THR_LSB +: CFG_THR_W]))
      else $error("fragment burst below threshold");
   handle_ptr_a: assert property (handle_push |->
      handle_data == desc_q) else $error("handle is not the descriptor");
   req_pulse_a: assert property (mreq |=> !mreq)
      else $error("request longer than one cycle");
endmodule

// ### tb/txd_host_mem.sv
// Behavioural host memory answering the engine's bus requests
module txd_host_mem
   import txd_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic mreq,
   input txd_kind_t mreq_kind,
   input wire logic [31:0] mreq_addr,
   input wire logic [15:0] mreq_len,
   input wire logic [15:0] mreq_wdata,
   input wire logic [3:0] dly,
   output logic bus_transfer_complete,
   output logic mrd_valid,
   output logic [1:0] mrd_index,
   output logic [31:0] mrd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:255];
   logic busy_q;
   logic [3:0] wait_q;
   logic [2:0] widx_q, nwords_q;
   logic [7:0] base_q;
   // One request at a time; all words go out before the completion
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busy_q <= 1'b0;
         bus_transfer_complete <= 1'b0;
         mrd_valid <= 1'b0;
         mrd_index <= 2'h0;
         mrd_data <= 32'h0000_0000;
      end else begin
         bus_transfer_complete <= 1'b0;
         mrd_valid <= 1'b0;
         mrd_data <= ~mrd_data; // Idle bus never repeats a stale word
         if (mreq) begin
            busy_q <= 1'b1;
            wait_q <= dly;
            widx_q <= 3'h0;
            base_q <= mreq_addr[9:2];
            nwords_q <= (mreq_kind == TXD_K_SWR || mreq_kind == TXD_K_FRAG)
               ? 3'h0 : mreq_len[4:2];
            if (mreq_kind == TXD_K_SWR) begin
               mem[mreq_addr[9:2]][31:16] <= mreq_wdata; // Upper half only
            end
         end else if (busy_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (busy_q && widx_q < nwords_q) begin
            mrd_valid <= 1'b1;
            mrd_index <= widx_q[1:0];
            mrd_data <= mem[base_q + 8'(widx_q)];
            widx_q <= widx_q + 3'h1;
         end else if (busy_q) begin
            busy_q <= 1'b0;
            bus_transfer_complete <= 1'b1;
         end
      end
   end
endmodule

// ### tb/testbench.sv
// Self-checking bench of the transmit descriptor engine
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import txd_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] fill = 12'h000;
   logic [3:0] dly = 4'h0;
   logic [31:0] reg_rdata, mreq_addr, mrd_data, handle_data;
   logic [15:0] mreq_len, mreq_wdata;
   logic irq, mreq, cpl, mrd_valid, handle_push;
   logic [1:0] mrd_index;
   txd_kind_t mreq_kind;
   logic [63:0] reqs [$];
   logic [31:0] handles [$];
   int n_errors = 0, n_checks = 0;
   txd_dma #(.FIFO_BYTES(2048), .FILL_W(12)) i_dut (.mclk(mclk),
      .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .mreq(mreq), .mreq_kind(mreq_kind), .mreq_addr(mreq_addr),
      .mreq_len(mreq_len), .mreq_wdata(mreq_wdata),
      .bus_transfer_complete(cpl), .mrd_valid(mrd_valid),
      .mrd_index(mrd_index), .mrd_data(mrd_data),
      .tx_fifo_fill_bytes(fill), .handle_push(handle_push),
      .handle_data(handle_data));
   txd_host_mem i_mem (.mclk(mclk), .rstn(rstn), .mreq(mreq),
      .mreq_kind(mreq_kind), .mreq_addr(mreq_addr), .mreq_len(mreq_len),
      .mreq_wdata(mreq_wdata), .dly(dly), .bus_transfer_complete(cpl),
      .mrd_valid(mrd_valid), .mrd_index(mrd_index), .mrd_data(mrd_data));
   always #5 mclk = ~mclk;
   // Log every bus request and handle for the scenarios to inspect
   always @(posedge mclk) begin
      if (mreq === 1'b1) reqs.push_back({mreq_kind, mreq_len, mreq_addr});
      if (handle_push === 1'b1) handles.push_back(handle_data);
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic exp_req(input txd_kind_t k, input logic [31:0] a,
                          input logic [15:0] l);
      chk("bus request", reqs.size() ? reqs.pop_front() : 'x,
          {k, l, a});
   endtask
   task automatic exp_handle(input logic [31:0] h);
      chk("handle", handles.size() ? handles.pop_front() : 'x, h);
   endtask
   task automatic desc(input int w, input logic [31:0] lk, cs, bp);
      i_mem.mem[w] = lk;
      i_mem.mem[w+1] = cs;
      i_mem.mem[w+2] = bp;
   endtask
   // Poll the state readback until the engine rests, bounded
   task automatic wait_idle();
      logic [31:0] s;
      for (int i = 0; i < 300; i++) begin
         rd(REG_STAT, s);
         if (s[18:16] === 3'h0) return;
      end
      n_errors++;
      close_out();
   endtask
   task automatic t_reset();
      logic [31:0] v;
      rd(REG_CMD, v);
      chk("cmd", v, 0);
      rd(REG_CFG, v);
      chk("cfg", v, CFG_RESET);
      rd(REG_ISR, v);
      chk("isr", v, 0);
      rd(REG_IMR, v);
      chk("imr", v, 0);
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18, v);
      chk("unmapped", v, 0);
      wr(REG_PTR, 32'hA5A5_5A5C);
      rd(REG_PTR, v);
      chk("pointer", v, 32'hA5A5_5A5C);
      $display("test reset done");
   endtask
   task automatic t_single();
      logic [31:0] v;
      desc(16, 32'h0, 32'h8000_0064, 32'h0000_1000);
      fill <= 12'h7C0; // Free space equals the threshold
      wr(REG_IMR, 32'h1);
      wr(REG_PTR, 32'h40);
      wr(REG_CMD, 32'h1);
      repeat (30) @(posedge mclk);
      chk("held at threshold", reqs.size(), 1);
      ce <= 1'b0;
      fill <= 12'h7B0;
      repeat (20) @(posedge mclk);
      chk("frozen by enable", reqs.size(), 1);
      ce <= 1'b1;
      wait_idle();
      exp_req(TXD_K_DREAD, 32'h40, 16'h000C);
      exp_req(TXD_K_FRAG, 32'h1000, 16'h0050);
      exp_req(TXD_K_FRAG, 32'h1050, 16'h0014);
      exp_handle(32'h40);
      chk("irq raised", irq, 1);
      rd(REG_ISR, v);
      chk("isr", v, 3);
      rd(REG_CMD, v);
      chk("go cleared", v, 0);
      rd(REG_STAT, v);
      chk("done", v[12], 1);
      chk("irq cleared", irq, 0);
      $display("test single done");
   endtask
   task automatic t_refresh();
      logic [31:0] v;
      dly <= 4'h3;
      wr(REG_IMR, 32'h0);
      i_mem.mem[16] = 32'h80;
      desc(32, 32'h0, 32'h8000_0008, 32'h0000_4000);
      wr(REG_CMD, 32'h1);
      wait_idle();
      exp_req(TXD_K_DREFR, 32'h40, 16'h0004);
      exp_req(TXD_K_DREAD, 32'h80, 16'h000C);
      exp_req(TXD_K_FRAG, 32'h4000, 16'h0008);
      exp_handle(32'h80);
      chk("irq masked", irq, 0);
      rd(REG_PTR, v);
      chk("pointer", v, 32'h80);
      rd(REG_ISR, v);
      chk("isr", v, 3);
      $display("test refresh done");
   endtask
   task automatic t_multi();
      logic [31:0] v;
      dly <= 4'h1;
      fill <= 12'h000;
      desc(48, 32'hD0, 32'hC000_0010, 32'h0000_2000);
      desc(52, 32'h0, 32'h8000_0008, 32'h0000_3000);
      rd(REG_STAT, v);
      chk("done set", v[12], 1);
      wr(REG_PTR, 32'hC0);
      rd(REG_STAT, v);
      chk("done cleared", v[12], 0);
      wr(REG_CMD, 32'h1);
      wait_idle();
      exp_req(TXD_K_DREAD, 32'hC0, 16'h000C);
      exp_req(TXD_K_FRAG, 32'h2000, 16'h0010);
      exp_req(TXD_K_SWR, 32'hC6, 16'h0002);
      exp_req(TXD_K_DREAD, 32'hD0, 16'h000C);
      exp_req(TXD_K_FRAG, 32'h3000, 16'h0008);
      exp_handle(32'hD0);
      chk("status word", i_mem.mem[49], 32'h4000_0010);
      rd(REG_ISR, v);
      chk("isr", v, 7);
      $display("test multi done");
   endtask
   task automatic t_unowned();
      logic [31:0] v;
      desc(64, 32'h0, 32'h0000_0010, 32'h0000_5000);
      wr(REG_PTR, 32'h100);
      wr(REG_CMD, 32'h1);
      for (int i = 0; i < 300 && reqs.size() < 2; i++) @(posedge mclk);
      exp_req(TXD_K_DREAD, 32'h100, 16'h000C);
      exp_req(TXD_K_DREAD, 32'h100, 16'h000C);
      rd(REG_ISR, v);
      chk("idle event", v[0], 1);
      $display("test unowned done");
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_single();
      t_refresh();
      t_multi();
      t_unowned();
      close_out();
   end
endmodule
bind txd_dma txd_dma_sva #(.FIFO_BYTES(FIFO_BYTES), .FILL_W(FILL_W)) i_sva (
   .mclk(mclk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mreq(mreq),
   .mreq_kind(mreq_kind), .mreq_addr(mreq_addr), .mreq_len(mreq_len),
   .mreq_wdata(mreq_wdata), .tx_fifo_fill_bytes(tx_fifo_fill_bytes),
   .handle_push(handle_push), .handle_data(handle_data));
